// *** logic/pjpc_pkg.sv ***
package pjpc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DATA  = 8'h28;
  localparam logic [7:0] IDX_PIN_LEVEL  = 8'h29;
  localparam logic [7:0] IDX_DIRECTION  = 8'h2A;
  localparam logic [7:0] IDX_DRIVE      = 8'h2B;
  localparam logic [7:0] IDX_PULL_EN    = 8'h2C;
  localparam logic [7:0] IDX_POLARITY   = 8'h2D;
  localparam logic [7:0] IDX_IRQ_EN     = 8'h2E;
  localparam logic [7:0] IDX_IRQ_FLAGS  = 8'h2F;
  // Pin layout
  localparam logic [7:0] IMPL_MASK      = 8'hC3;
  localparam logic [7:0] PERIPH_MASK    = 8'hC0;
  localparam logic [7:0] CAN_RX_MASK    = 8'h40;
  // Reset values
  localparam logic [7:0] RST_PORT_DATA  = 8'h00;
  localparam logic [7:0] RST_DIRECTION  = 8'h00;
  localparam logic [7:0] RST_DRIVE      = 8'h00;
  localparam logic [7:0] RST_PULL_EN    = 8'hC3;
  localparam logic [7:0] RST_POLARITY   = 8'h00;
  localparam logic [7:0] RST_IRQ_EN     = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS  = 8'h00;
  // Edge filter: samples of each level
  localparam int unsigned FILTER_SAMPLES = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage : pjpc_pkg

// *** logic/pjpc_port.sv ***
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module pjpc_port #(
  parameter int unsigned ADDR_W   = 8,
  parameter int unsigned FILTER_N = pjpc_pkg::FILTER_SAMPLES
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic [7:0]        pin_in,
  output logic [7:0]             pin_out,
  output logic [7:0]             pin_oe,
  output logic [7:0]             pin_reduced,
  output logic [7:0]             pin_pull_up,
  output logic [7:0]             pin_pull_down,
  // CAN controller
  input  wire logic              can_enable,
  input  wire logic              can_transmit_pin,
  output logic                   can_receive_pin,
  // Two-wire controller
  input  wire logic              iic_enable,
  input  wire logic              iic_scl_drive_low,
  input  wire logic              iic_sda_drive_low,
  output logic                   iic_scl_in,
  output logic                   iic_sda_in,
  // Interrupt
  output logic                   irq
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("pjpc_port: ADDR_W must be 8 to 32");
  end
  if (FILTER_N < 1 || FILTER_N > 8) begin : g_bad_filter
    $error("pjpc_port: FILTER_N must be 1 to 8");
  end

  logic [7:0] port_data;
  logic [7:0] pin_direction;
  logic [7:0] drive_strength_select;
  logic [7:0] pull_enable;
  logic [7:0] polarity_select;
  logic [7:0] edge_irq_enable;
  logic [7:0] edge_irq_flags;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] edge_hit;
  logic       wr_accept;
  logic       rd_accept;

  // Input synchroniser
  always_ff @(posedge aclk)
  begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end

  // Pin ownership and pad control
  wire        can_own    = can_enable;
  wire        iic_own    = iic_enable & ~can_enable;
  wire [7:0]  periph_sel = (can_own | iic_own) ? pjpc_pkg::PERIPH_MASK : 8'h00;
  wire [7:0]  iic_sel    = iic_own ? pjpc_pkg::PERIPH_MASK : 8'h00;
  wire [7:0]  periph_oe  = can_own ? 8'h80
                         : {iic_scl_drive_low, iic_sda_drive_low, 6'h00};
  wire [7:0]  periph_out = can_own ? {can_transmit_pin, 7'h00} : 8'h00;
  wire [7:0]  next_oe    = ((periph_sel & periph_oe)
                         | (~periph_sel & pin_direction))
                         & pjpc_pkg::IMPL_MASK;
  wire [7:0]  next_out   = ((periph_sel & periph_out)
                         | (~periph_sel & port_data))
                         & pjpc_pkg::IMPL_MASK;
  wire [7:0]  input_use  = ((~periph_sel & ~pin_direction)
                         | (can_own ? pjpc_pkg::CAN_RX_MASK : 8'h00))
                         & pjpc_pkg::IMPL_MASK;
  wire [7:0]  next_pull_up   = pull_enable & ~polarity_select
                             & (input_use | iic_sel);
  wire [7:0]  next_pull_down = pull_enable & polarity_select
                             & input_use;
  wire [7:0]  next_reduced   = drive_strength_select & next_oe;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_oe        <= 8'h00;
      pin_out       <= 8'h00;
      pin_reduced   <= 8'h00;
      pin_pull_up   <= 8'h00;
      pin_pull_down <= 8'h00;
    end
    else
    begin
      pin_oe        <= next_oe;
      pin_out       <= next_out;
      pin_reduced   <= next_reduced;
      pin_pull_up   <= next_pull_up;
      pin_pull_down <= next_pull_down;
    end
  end

  // Peripheral inputs from the synchronised pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      can_receive_pin <= 1'b1;
      iic_scl_in      <= 1'b1;
      iic_sda_in      <= 1'b1;
    end
    else
    begin
      can_receive_pin <= pin_sync[6];
      iic_scl_in      <= pin_sync[7];
      iic_sda_in      <= pin_sync[6];
    end
  end

  // Edge filter per pin
  for (genvar i = 0; i < 8; i++) begin : g_filter
    logic [2*FILTER_N-1:0] hist;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        hist <= '1;
      else
        hist <= {hist[2*FILTER_N-2:0], pin_sync[i]};
    end
    assign edge_hit[i] = pjpc_pkg::IMPL_MASK[i]
                       & (hist == {{FILTER_N{~polarity_select[i]}},
                                   {FILTER_N{polarity_select[i]}}});
  end

  // Bus decode
  wire [ADDR_W-3:0] wr_word   = s_axi_awaddr[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_word   = s_axi_araddr[ADDR_W-1:2];
  wire [ADDR_W-3:0] map_base  = (ADDR_W-2)'(pjpc_pkg::IDX_PORT_DATA >> 3);
  wire              wr_in_map = (wr_word >> 3) == map_base;
  wire              rd_in_map = (rd_word >> 3) == map_base;
  wire [2:0]        wr_sel    = wr_word[2:0];
  wire [2:0]        rd_sel    = rd_word[2:0];
  wire              wr_hs     = wr_accept;
  wire              wr_do     = wr_hs & wr_in_map & s_axi_wstrb[0];
  wire [7:0]        wbyte     = s_axi_wdata[7:0] & pjpc_pkg::IMPL_MASK;
  wire we_data  = wr_do & (wr_sel == pjpc_pkg::IDX_PORT_DATA[2:0]);
  wire we_dir   = wr_do & (wr_sel == pjpc_pkg::IDX_DIRECTION[2:0]);
  wire we_drive = wr_do & (wr_sel == pjpc_pkg::IDX_DRIVE[2:0]);
  wire we_pull  = wr_do & (wr_sel == pjpc_pkg::IDX_PULL_EN[2:0]);
  wire we_pol   = wr_do & (wr_sel == pjpc_pkg::IDX_POLARITY[2:0]);
  wire we_ien   = wr_do & (wr_sel == pjpc_pkg::IDX_IRQ_EN[2:0]);
  wire we_flag  = wr_do & (wr_sel == pjpc_pkg::IDX_IRQ_FLAGS[2:0]);
  wire [7:0] flag_clr   = we_flag ? wbyte : 8'h00;
  wire [7:0] next_flags = (edge_irq_flags & ~flag_clr)
                        | edge_hit;
  wire [7:0] data_view  = ((pin_direction & port_data)
                        | (~pin_direction & pin_sync))
                        & pjpc_pkg::IMPL_MASK;
  wire [7:0] rd_mux =
      (rd_sel == pjpc_pkg::IDX_PORT_DATA[2:0]) ? data_view
    : (rd_sel == pjpc_pkg::IDX_PIN_LEVEL[2:0]) ? pin_sync & pjpc_pkg::IMPL_MASK
    : (rd_sel == pjpc_pkg::IDX_DIRECTION[2:0]) ? pin_direction
    : (rd_sel == pjpc_pkg::IDX_DRIVE[2:0])     ? drive_strength_select
    : (rd_sel == pjpc_pkg::IDX_PULL_EN[2:0])   ? pull_enable
    : (rd_sel == pjpc_pkg::IDX_POLARITY[2:0])  ? polarity_select
    : (rd_sel == pjpc_pkg::IDX_IRQ_EN[2:0])    ? edge_irq_enable
    : edge_irq_flags;

  // Configuration registers, writable at any time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_data             <= pjpc_pkg::RST_PORT_DATA;
      pin_direction         <= pjpc_pkg::RST_DIRECTION;
      drive_strength_select <= pjpc_pkg::RST_DRIVE;
      pull_enable           <= pjpc_pkg::RST_PULL_EN;
      polarity_select       <= pjpc_pkg::RST_POLARITY;
      edge_irq_enable       <= pjpc_pkg::RST_IRQ_EN;
    end
    else
    begin
      if (we_data)  port_data             <= wbyte;
      if (we_dir)   pin_direction         <= wbyte;
      if (we_drive) drive_strength_select <= wbyte;
      if (we_pull)  pull_enable           <= wbyte;
      if (we_pol)   polarity_select       <= wbyte;
      if (we_ien)   edge_irq_enable       <= wbyte;
    end
  end

  // Flags and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_irq_flags <= pjpc_pkg::RST_IRQ_FLAGS;
      irq            <= 1'b0;
    end
    else
    begin
      edge_irq_flags <= next_flags;
      irq            <= |(edge_irq_flags & edge_irq_enable);
    end
  end

  // Write channel
  assign s_axi_awready = wr_accept;
  assign s_axi_wready  = wr_accept;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_accept    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pjpc_pkg::RESP_OKAY;
    end
    else
    begin
      wr_accept <= s_axi_awvalid & s_axi_wvalid & ~wr_accept & ~s_axi_bvalid;
      if (wr_hs)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_in_map ? pjpc_pkg::RESP_OKAY : pjpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  assign s_axi_arready = rd_accept;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_accept    <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pjpc_pkg::RESP_OKAY;
    end
    else
    begin
      rd_accept <= s_axi_arvalid & ~rd_accept & ~s_axi_rvalid;
      if (rd_accept)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_in_map ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        s_axi_rresp  <= rd_in_map ? pjpc_pkg::RESP_OKAY : pjpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire rd_lvl = rd_accept & rd_in_map & (rd_sel == pjpc_pkg::IDX_PIN_LEVEL[2:0]);
  wire rd_dat = rd_accept & rd_in_map & (rd_sel == pjpc_pkg::IDX_PORT_DATA[2:0]);

  property p_pin_level_read;
    rd_lvl |=> s_axi_rdata[7:0] == ($past(pin_sync) & pjpc_pkg::IMPL_MASK);
  endproperty
  a_pin_level_read: assert property (p_pin_level_read)
    else $error("pin level read mismatch");

  property p_gpio_dir;
    (!can_enable && !iic_enable) |=> pin_oe[7] == $past(pin_direction[7]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("general I/O direction not applied");

  property p_can_force;
    can_enable |=> pin_oe[7] && !pin_oe[6] && pin_out[7] == $past(can_transmit_pin);
  endproperty
  a_can_force: assert property (p_can_force)
    else $error("CAN pin direction not forced");

  property p_iic_open_drain;
    (!can_enable && iic_enable) |=> pin_oe[6] == $past(iic_sda_drive_low)
      && !pin_out[6] && !pin_out[7];
  endproperty
  a_iic_open_drain: assert property (p_iic_open_drain)
    else $error("two-wire pin not open-drain");

  property p_flag_set;
    edge_hit[0] |=> edge_irq_flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("edge did not set flag");

  property p_flag_clear;
    (we_flag && s_axi_wdata[0] && !edge_hit[0]) |=> !edge_irq_flags[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("write one did not clear flag");

  property p_irq;
    (|(edge_irq_flags & edge_irq_enable)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_filter_fall;
    ($rose(edge_irq_flags[0]) && !polarity_select[0] && $stable(polarity_select[0]))
      |-> !$past(pin_sync[0], 2) && !$past(pin_sync[0], 5)
      && $past(pin_sync[0], 6) && $past(pin_sync[0], 9);
  endproperty
  a_filter_fall: assert property (p_filter_fall)
    else $error("flag set without filtered edge");

  property p_data_read;
    (rd_dat && pin_direction[1]) |=> s_axi_rdata[1] == $past(port_data[1]);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read ignores direction");

  property p_reset_inputs;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> pin_oe == 8'h00;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pin driven during reset");

endmodule : pjpc_port

// *** sim/pjpc_pads.sv ***
`timescale 1ns/1ps
// Board pads: port drive wins, then board drive, then pulls, else floating
module pjpc_pads (
  // Clock
  input  wire logic       aclk,
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_down,
  // Board drive
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Pad level
  output logic      [7:0] pin_level
);
  logic [7:0] last = 8'h00;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                     pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : ~last[i];
    end
  end

  // Floating pads toggle so a stale level is never mistaken for a driven one
  always_ff @(posedge aclk)
  begin
    last <= pin_level;
  end
endmodule : pjpc_pads

// *** sim/port_j_pin_control_tb_top.sv ***
`timescale 1ns/1ps
module port_j_pin_control_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  pin_level, pin_out, pin_oe, pin_reduced, pin_pull_up, pin_pull_down;
  logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
  logic        can_enable = 1'b0, can_transmit_pin = 1'b1, can_receive_pin;
  logic        iic_enable = 1'b0, iic_scl_drive_low = 1'b0, iic_sda_drive_low = 1'b0;
  logic        iic_scl_in, iic_sda_in, irq;
  int          errors = 0;
  int          cmp_count = 0;
  logic [7:0]  rst_exp [8] = '{8'hC3, 8'hC3, 8'h00, 8'h00, 8'hC3, 8'h00, 8'h00, 8'h00};

  always #4 aclk = ~aclk;

  pjpc_port pjpc_port_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in(pin_level), .pin_out, .pin_oe, .pin_reduced,
    .pin_pull_up, .pin_pull_down, .can_enable, .can_transmit_pin, .can_receive_pin,
    .iic_enable, .iic_scl_drive_low, .iic_sda_drive_low, .iic_scl_in, .iic_sda_in, .irq
  );

  pjpc_pads pjpc_pads_inst (
    .aclk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_en, .ext_val, .pin_level
  );

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
  endtask : tick

  task automatic lim(input int n);
    if (n >= 50)
    begin
      $display("mismatch handshake expected answer seen none");
      errors++;
      print_verdict();
    end
  endtask : lim

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= {idx[5:0], 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do tick(n); while (s_axi_awready !== 1'b1 && n < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    while (s_axi_bvalid !== 1'b1 && n < 50) tick(n);
    s_axi_bready <= 1'b0;
    lim(n);
    chk("bresp", {6'h0, er}, {6'h0, s_axi_bresp});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && n < 50) tick(n);
    s_axi_rready <= 1'b0;
    lim(n);
    chk("rresp", {6'h0, er}, {6'h0, s_axi_rresp});
    chk("rdata", ex, s_axi_rdata[7:0]);
    chk("rdata_hi", 8'h00, {7'h0, |s_axi_rdata[31:8]});
    @(posedge aclk);
  endtask : rd

  initial
  begin
    repeat (3) @(posedge aclk);
    chk("pin_oe", 8'h00, pin_oe);
    aresetn <= 1'b1;
    cyc(6);
    for (int i = 0; i < 8; i++)
      rd(8'h28 + 8'(i), rst_exp[i], 2'h0);
    $display("test reset done");
    rd(8'h30, 8'h00, 2'h2);
    wr(8'h20, 8'hFF, 2'h2);
    wr(pjpc_pkg::IDX_PIN_LEVEL, 8'h00, 2'h0);
    rd(pjpc_pkg::IDX_PIN_LEVEL, 8'hC3, 2'h0);
    wr(pjpc_pkg::IDX_DIRECTION, 8'hFF, 2'h0);
    rd(pjpc_pkg::IDX_DIRECTION, 8'hC3, 2'h0);
    $display("test access done");
    wr(pjpc_pkg::IDX_POLARITY, 8'hC0, 2'h0);
    wr(pjpc_pkg::IDX_DRIVE, 8'hC3, 2'h0);
    wr(pjpc_pkg::IDX_PORT_DATA, 8'hC2, 2'h0);
    wr(pjpc_pkg::IDX_DIRECTION, 8'h03, 2'h0);
    cyc(4);
    chk("pin_oe", 8'h03, pin_oe & 8'hC3);
    chk("pin_out", 8'h02, pin_out & 8'h03);
    chk("pin_reduced", 8'h03, pin_reduced & 8'hC3);
    chk("pin_pull_down", 8'hC0, pin_pull_down & 8'hC3);
    chk("pin_pull_up", 8'h00, pin_pull_up & 8'hC3);
    rd(pjpc_pkg::IDX_PORT_DATA, 8'h02, 2'h0);
    rd(pjpc_pkg::IDX_PIN_LEVEL, 8'h02, 2'h0);
    rd(pjpc_pkg::IDX_DRIVE, 8'hC3, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(pjpc_pkg::IDX_DRIVE, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(pjpc_pkg::IDX_DRIVE, 8'hC3, 2'h0);
    $display("test gpio done");
    wr(pjpc_pkg::IDX_POLARITY, 8'h00, 2'h0);
    wr(pjpc_pkg::IDX_DIRECTION, 8'h40, 2'h0);
    can_enable <= 1'b1;
    cyc(4);
    chk("pin_oe", 8'h80, pin_oe & 8'hC0);
    chk("pin_out", 8'h80, pin_out & 8'h80);
    chk("pin_pull_up", 8'h40, pin_pull_up & 8'hC0);
    chk("can_receive_pin", 8'h01, {7'h0, can_receive_pin});
    can_transmit_pin <= 1'b0;
    ext_en <= 8'h40;
    cyc(4);
    chk("pin_out", 8'h00, pin_out & 8'h80);
    chk("can_receive_pin", 8'h00, {7'h0, can_receive_pin});
    ext_en <= 8'h00;
    can_transmit_pin <= 1'b1;
    rd(pjpc_pkg::IDX_DIRECTION, 8'h40, 2'h0);
    can_enable <= 1'b0;
    cyc(3);
    chk("pin_oe", 8'h40, pin_oe & 8'hC0);
    iic_enable <= 1'b1;
    iic_scl_drive_low <= 1'b1;
    cyc(5);
    chk("pin_oe", 8'h80, pin_oe & 8'hC0);
    chk("pin_out", 8'h00, pin_out & 8'h80);
    chk("pin_pull_up", 8'hC0, pin_pull_up & 8'hC0);
    chk("iic_in", 8'h01, {6'h0, iic_scl_in, iic_sda_in});
    iic_scl_drive_low <= 1'b0;
    iic_enable <= 1'b0;
    wr(pjpc_pkg::IDX_DIRECTION, 8'h00, 2'h0);
    $display("test owner done");
    cyc(6);
    wr(pjpc_pkg::IDX_IRQ_FLAGS, 8'hFF, 2'h0);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h00, 2'h0);
    wr(pjpc_pkg::IDX_IRQ_EN, 8'h01, 2'h0);
    ext_en <= 8'h01;
    ext_val <= 8'h00;
    cyc(20);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h01, 2'h0);
    chk("irq", 8'h01, {7'h0, irq});
    wr(pjpc_pkg::IDX_IRQ_FLAGS, 8'h00, 2'h0);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h01, 2'h0);
    wr(pjpc_pkg::IDX_IRQ_EN, 8'h00, 2'h0);
    cyc(2);
    chk("irq", 8'h00, {7'h0, irq});
    wr(pjpc_pkg::IDX_IRQ_FLAGS, 8'h01, 2'h0);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h00, 2'h0);
    $display("test flags done");
    wr(pjpc_pkg::IDX_POLARITY, 8'h02, 2'h0);
    ext_en <= 8'h03;
    cyc(10);
    ext_val <= 8'h02;
    cyc(3);
    ext_val <= 8'h00;
    cyc(20);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h00, 2'h0);
    ext_val <= 8'h02;
    cyc(20);
    rd(pjpc_pkg::IDX_IRQ_FLAGS, 8'h02, 2'h0);
    $display("test filter done");
    print_verdict();
  end
endmodule : port_j_pin_control_tb_top
